/* common/sop_pkg.sv */
// Shared constants and types for the four-port serial I/Q output block.
`default_nettype none
package sop_pkg;
   localparam int          SOP_PORTS        = 4;
   localparam int          SOP_ADDR_W       = 10;
   localparam int          SOP_DATA_W       = 16;
   localparam int          SOP_SAMPLE_W     = 24;
   localparam int          SOP_FRAME_W      = 48;
   // Per-port register offsets; address bits 9-8 select the port.
   localparam logic [7:0]  SOP_OFS_FORMAT   = 8'hA4;
   localparam logic [7:0]  SOP_OFS_PORTCFG  = 8'hA9;
   localparam logic [7:0]  SOP_OFS_STATUS   = 8'hAA;
   // Format register fields.
   localparam int          SOP_FMT_WLEN_LSB = 0;
   localparam int          SOP_FMT_FSM_LSB  = 2;
   localparam int          SOP_FMT_OFMT_LSB = 4;
   localparam int          SOP_FMT_FORCE    = 6;
   localparam int          SOP_FMT_COMMON   = 7;
   localparam int          SOP_FMT_SCALE_LSB = 8;
   localparam logic [15:0] SOP_FMT_RESET    = 16'h0000;
   // Port configuration register fields.
   localparam int          SOP_CFG_DIV_LSB  = 0;
   localparam int          SOP_CFG_MASTER   = 4;
   localparam logic [15:0] SOP_CFG_RESET    = 16'h0000;
   // Status register fields.
   localparam int          SOP_ST_READY     = 0;
   localparam int          SOP_ST_BUSY      = 1;
   localparam int          SOP_ST_MASTER    = 2;
   // Field encodings.
   localparam logic [1:0]  SOP_WLEN_12      = 2'h0;
   localparam logic [1:0]  SOP_WLEN_16      = 2'h1;
   localparam logic [1:0]  SOP_WLEN_24      = 2'h2;
   localparam logic [1:0]  SOP_OFMT_LINEAR  = 2'h0;
   localparam logic [1:0]  SOP_OFMT_F8E4    = 2'h1;
   localparam logic [1:0]  SOP_OFMT_F12E4   = 2'h2;
   localparam logic [1:0]  SOP_FSM_ONE      = 2'h0;
   localparam logic [1:0]  SOP_FSM_HIGH     = 2'h1;
   localparam logic [1:0]  SOP_FSM_EACH     = 2'h2;
   localparam logic [5:0]  SOP_COMPACT_LEN  = 6'h14;
   localparam logic [5:0]  SOP_COMPACT_WORD = 6'h0C;
   typedef enum logic [1:0] {SOP_IDLE, SOP_SYNC, SOP_SHIFT} sop_state_t;
endpackage
`default_nettype wire

/* rtl/sop_serial_out.sv */
// Four independent serial output ports that format and shift out I/Q samples.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Four ports, each independently configured as master or slave.
// - Word length per port is 12, 16 or 24 bits.
// - Linear, 8+4 or 12+4 floating-point formats; 12+4 in a 12-bit word keeps only the mantissa.
// - Linear words are scaled by a programmable 4-bit left shift.
// - Every word goes out most significant bit first.
// - Exponent is automatic per I and Q, or shared in common mode.
// - Automatic exponent picks the smallest shift up to 15 that cannot overflow, else 15.
// - A fixed exponent from the scale field can be forced.
// - Compact order: I mantissa, I exponent, Q mantissa, Q exponent.
// - Compact frames are exactly 20 bits; trailing Q exponent is dropped.
// - Compact needs decimation 20, format 01 and common exponent set.
// - A finished sample fills the buffer; master syncs on next serial edge.
// - Sync mode one: sync for one serial cycle, then data.
// - Frame is all I bits followed directly by all Q bits.
// - Sync mode two: sync high with the first bit and during all data.
// - Sync mode three: sync pulse before first I bit and before first Q bit.
// - Frame end is high during the last Q bit in every mode.
// - Slave samples sync on a rising edge and shifts from the next one.
// - Ready flag shows a buffered frame waiting to be sent.
// - Master serial clock is master clock over divider plus one; a divider of zero runs as one.
// - Ports 1-3 reset as slaves; port 0 role comes from a strap pin.
module sop_serial_out
   import sop_pkg::*;
(
   input  wire logic                                        CLK_SYS,
   input  wire logic                                        RST_N,
   input  wire logic [sop_pkg::SOP_ADDR_W-1:0]              ADDR,
   input  wire logic [sop_pkg::SOP_DATA_W-1:0]              WDATA,
   input  wire logic                                        WR,
   input  wire logic                                        RD,
   output logic      [sop_pkg::SOP_DATA_W-1:0]              RDATA,
   input  wire logic                                        BUS_MASTER_SELECT0,
   input  wire logic [3:0]                                  SERIAL_CLOCK_DIVIDER0,
   input  wire logic [sop_pkg::SOP_PORTS-1:0]               DECIM_IS_20,
   input  wire logic [sop_pkg::SOP_PORTS-1:0]               SAMPLE_VALID,
   input  wire logic [sop_pkg::SOP_PORTS-1:0][23:0]         SAMPLE_I,
   input  wire logic [sop_pkg::SOP_PORTS-1:0][23:0]         SAMPLE_Q,
   input  wire logic [sop_pkg::SOP_PORTS-1:0]               SERIAL_CLOCK_I,
   output logic      [sop_pkg::SOP_PORTS-1:0]               SERIAL_CLOCK_O,
   output logic      [sop_pkg::SOP_PORTS-1:0]               SERIAL_CLOCK_OE_N,
   input  wire logic [sop_pkg::SOP_PORTS-1:0]               FRAME_SYNC_I,
   output logic      [sop_pkg::SOP_PORTS-1:0]               FRAME_SYNC_O,
   output logic      [sop_pkg::SOP_PORTS-1:0]               FRAME_SYNC_OE_N,
   output logic      [sop_pkg::SOP_PORTS-1:0]               SERIAL_DATA_OUT,
   output logic      [sop_pkg::SOP_PORTS-1:0]               SERIAL_DATA_OUT_OE_N,
   output logic      [sop_pkg::SOP_PORTS-1:0]               FRAME_END,
   output logic      [sop_pkg::SOP_PORTS-1:0]               FRAME_READY_FLAG
);
   import sop_pkg::*;

   // Smallest right shift up to 15 that keeps the sample inside an m-bit signed mantissa, else 15.
   function automatic logic [3:0] auto_exp(input logic [23:0] s, input int m);
      int         v;
      int         lim;
      logic [3:0] e;
      lim = 1 << (m - 1);
      e   = 4'hF;
      for (int k = 15; k >= 0; k--)
      begin
         v = int'($signed(s)) >>> k;
         if (v >= -lim && v < lim)
            e = 4'(k);
      end
      return e;
   endfunction

   // Mask that keeps the top n bits of a 24-bit left-aligned word.
   function automatic logic [23:0] top_mask(input logic [5:0] n);
      logic [47:0] t;
      t = {24'hFFFFFF, 24'h000000} >> n;
      return t[23:0];
   endfunction

   // One word of the frame, left aligned in 24 bits.
   function automatic logic [23:0] fmt_word(input logic [23:0] s, input logic [1:0] ofmt, input logic [3:0] e,
                                            input logic [3:0] scale, input logic [5:0] wlen);
      int          v;
      logic [23:0] w;
      logic [23:0] m;
      v = int'($signed(s)) <<< scale;
      if (v > 32'sh007FFFFF)
         v = 32'sh007FFFFF;
      else if (v < -32'sh00800000)
         v = -32'sh00800000;
      m = 24'($signed(s) >>> e);
      if (ofmt == SOP_OFMT_F8E4)
         w = {m[7:0], e, 12'h000};
      else if (ofmt == SOP_OFMT_F12E4)
         w = {m[11:0], e, 8'h00};
      else
         w = v[23:0];
      return w & top_mask(wlen);
   endfunction

   logic [SOP_PORTS-1:0][15:0] fmt_reg;
   logic [SOP_PORTS-1:0][15:0] cfg_reg;
   logic                       strap_done;
   logic                       master0;
   logic [1:0]                 rd_port;
   logic [7:0]                 rd_ofs;
   logic                       rd_q;

   // Port 0 role is caught from its strap in the first cycle after reset release.
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         strap_done <= 1'b0;
         master0    <= 1'b0;
      end
      else if (!strap_done)
      begin
         strap_done <= 1'b1;
         master0    <= BUS_MASTER_SELECT0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         for (int p = 0; p < SOP_PORTS; p++)
         begin
            fmt_reg[p] <= SOP_FMT_RESET;
            cfg_reg[p] <= SOP_CFG_RESET;
         end
      end
      else if (WR)
      begin
         if (ADDR[7:0] == SOP_OFS_FORMAT)
            fmt_reg[ADDR[9:8]] <= WDATA;
         else if (ADDR[7:0] == SOP_OFS_PORTCFG)
            cfg_reg[ADDR[9:8]] <= WDATA;
      end
   end

   logic       [SOP_PORTS-1:0] ready;
   logic       [SOP_PORTS-1:0] busy;
   logic       [SOP_PORTS-1:0] is_master;

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rd_q    <= 1'b0;
         rd_port <= 2'h0;
         rd_ofs  <= 8'h00;
      end
      else
      begin
         rd_q    <= RD;
         rd_port <= ADDR[9:8];
         rd_ofs  <= ADDR[7:0];
      end
   end

   // Read data stand only in the cycle after the strobe; unmapped offsets read zero.
   always_comb
   begin
      RDATA = 16'h0000;
      if (rd_q)
      begin
         if (rd_ofs == SOP_OFS_FORMAT)
            RDATA = fmt_reg[rd_port];
         else if (rd_ofs == SOP_OFS_PORTCFG)
            RDATA = cfg_reg[rd_port];
         else if (rd_ofs == SOP_OFS_STATUS)
            RDATA = {13'h0000, is_master[rd_port], busy[rd_port], ready[rd_port]};
      end
   end

   for (genvar p = 0; p < SOP_PORTS; p++)
   begin : g_port
      logic [1:0]              wsel;
      logic [1:0]              fsm;
      logic [1:0]              ofmt;
      logic [3:0]              scale;
      logic [3:0]              div;
      logic                    compact;
      logic [5:0]              wlen;
      logic [5:0]              flen;
      logic [3:0]              e_i;
      logic [3:0]              e_q;
      logic [3:0]              use_i;
      logic [3:0]              use_q;
      logic [23:0]             w_i;
      logic [23:0]             w_q;
      logic [3:0]              div_cnt;
      logic                    sclk_q;
      logic                    tick;
      sop_state_t              state;
      logic [5:0]              bit_cnt;
      logic [SOP_FRAME_W-1:0]  frame_buf;
      logic [SOP_FRAME_W-1:0]  shreg;
      logic                    start;

      assign wsel      = fmt_reg[p][SOP_FMT_WLEN_LSB +: 2];
      assign fsm       = fmt_reg[p][SOP_FMT_FSM_LSB +: 2];
      assign ofmt      = fmt_reg[p][SOP_FMT_OFMT_LSB +: 2];
      assign scale     = fmt_reg[p][SOP_FMT_SCALE_LSB +: 4];
      assign is_master[p] = (p == 0) ? master0 : cfg_reg[p][SOP_CFG_MASTER];
      assign div       = ((p == 0) ? SERIAL_CLOCK_DIVIDER0 : cfg_reg[p][SOP_CFG_DIV_LSB +: 4]) |
                         {3'h0, ((p == 0) ? SERIAL_CLOCK_DIVIDER0 : cfg_reg[p][SOP_CFG_DIV_LSB +: 4]) == 4'h0};
      assign compact   = DECIM_IS_20[p] && (ofmt == SOP_OFMT_F8E4) && fmt_reg[p][SOP_FMT_COMMON];
      assign wlen      = compact ? SOP_COMPACT_WORD :
                         (wsel == SOP_WLEN_24) ? 6'h18 : (wsel == SOP_WLEN_16) ? 6'h10 : 6'h0C;
      assign flen      = compact ? SOP_COMPACT_LEN : 6'(wlen << 1);

      // Overflow is avoided first, so the exponent may cost small-value precision.
      assign e_i   = auto_exp(SAMPLE_I[p], (ofmt == SOP_OFMT_F12E4) ? 12 : 8);
      assign e_q   = auto_exp(SAMPLE_Q[p], (ofmt == SOP_OFMT_F12E4) ? 12 : 8);
      assign use_i = fmt_reg[p][SOP_FMT_FORCE] ? scale :
                     fmt_reg[p][SOP_FMT_COMMON] ? ((e_i > e_q) ? e_i : e_q) : e_i;
      assign use_q = fmt_reg[p][SOP_FMT_FORCE] ? scale :
                     fmt_reg[p][SOP_FMT_COMMON] ? ((e_i > e_q) ? e_i : e_q) : e_q;
      assign w_i   = fmt_word(SAMPLE_I[p], ofmt, use_i, scale, wlen);
      assign w_q   = fmt_word(SAMPLE_Q[p], ofmt, use_q, scale, wlen);

      // A divider of zero would need a clock as fast as the system clock, so it runs as one.
      always_ff @(posedge CLK_SYS or negedge RST_N)
      begin
         if (!RST_N)
         begin
            div_cnt           <= 4'h0;
            sclk_q            <= 1'b0;
            SERIAL_CLOCK_O[p] <= 1'b0;
         end
         else
         begin
            sclk_q <= SERIAL_CLOCK_I[p];
            if (!is_master[p] || div_cnt >= div)
               div_cnt <= 4'h0;
            else
               div_cnt <= div_cnt + 4'h1;
            SERIAL_CLOCK_O[p] <= is_master[p] && (tick || (div_cnt < (div >> 1)));
         end
      end

      assign tick  = is_master[p] ? (div_cnt >= div) : (SERIAL_CLOCK_I[p] && !sclk_q);
      assign start = tick && (state == SOP_IDLE) &&
                     (is_master[p] ? ready[p] : FRAME_SYNC_I[p]);

      // Each finished sample lands in the buffer as a complete I-then-Q frame.
      always_ff @(posedge CLK_SYS or negedge RST_N)
      begin
         if (!RST_N)
            frame_buf <= 48'h000000000000;
         else if (SAMPLE_VALID[p])
            frame_buf <= {w_i, 24'h000000} | ({w_q, 24'h000000} >> wlen);
      end

      // A new sample in the same cycle as a frame start keeps the flag set.
      always_ff @(posedge CLK_SYS or negedge RST_N)
      begin
         if (!RST_N)
            ready[p] <= 1'b0;
         else if (SAMPLE_VALID[p])
            ready[p] <= 1'b1;
         else if (start)
            ready[p] <= 1'b0;
      end

      always_ff @(posedge CLK_SYS or negedge RST_N)
      begin
         if (!RST_N)
         begin
            state              <= SOP_IDLE;
            bit_cnt            <= 6'h00;
            shreg              <= 48'h000000000000;
            SERIAL_DATA_OUT[p] <= 1'b0;
            FRAME_SYNC_O[p]    <= 1'b0;
            FRAME_END[p]       <= 1'b0;
         end
         else if (tick)
         begin
            case (state)
               SOP_IDLE:
               begin
                  if (start && is_master[p] && fsm == SOP_FSM_HIGH)
                  begin
                     state              <= SOP_SHIFT;
                     bit_cnt            <= 6'h00;
                     SERIAL_DATA_OUT[p] <= frame_buf[SOP_FRAME_W-1];
                     shreg              <= frame_buf << 1;
                     FRAME_SYNC_O[p]    <= 1'b1;
                  end
                  else if (start)
                  begin
                     state           <= SOP_SYNC;
                     shreg           <= frame_buf;
                     FRAME_SYNC_O[p] <= is_master[p];
                  end
               end
               SOP_SYNC:
               begin
                  state              <= SOP_SHIFT;
                  bit_cnt            <= 6'h00;
                  SERIAL_DATA_OUT[p] <= shreg[SOP_FRAME_W-1];
                  shreg              <= shreg << 1;
                  FRAME_SYNC_O[p]    <= 1'b0;
                  FRAME_END[p]       <= (flen == 6'h01);
               end
               SOP_SHIFT:
               begin
                  if (bit_cnt + 6'h01 >= flen)
                  begin
                     state           <= SOP_IDLE;
                     FRAME_SYNC_O[p] <= 1'b0;
                     FRAME_END[p]    <= 1'b0;
                  end
                  else
                  begin
                     bit_cnt            <= bit_cnt + 6'h01;
                     SERIAL_DATA_OUT[p] <= shreg[SOP_FRAME_W-1];
                     shreg              <= shreg << 1;
                     FRAME_END[p]       <= (bit_cnt + 6'h02 == flen);
                     if (is_master[p] && fsm == SOP_FSM_HIGH)
                        FRAME_SYNC_O[p] <= 1'b1;
                     else
                        FRAME_SYNC_O[p] <= is_master[p] && fsm == SOP_FSM_EACH &&
                                           (bit_cnt + 6'h02 == wlen);
                  end
               end
               default:
                  state <= SOP_IDLE;
            endcase
         end
      end

      assign busy[p]                 = (state != SOP_IDLE);
      assign SERIAL_CLOCK_OE_N[p]    = !is_master[p];
      assign FRAME_SYNC_OE_N[p]      = !is_master[p];
      // Releasing the data pin outside frames lets cascaded ports share the line.
      assign SERIAL_DATA_OUT_OE_N[p] = (state != SOP_SHIFT);
      assign FRAME_READY_FLAG[p]     = ready[p];
   end

endmodule // sop_serial_out
`default_nettype wire

/* sim/sop_serial_out_props.sv */
// Checker for the serial output ports of the four-port I/Q block.
`timescale 1ns/1ps
`default_nettype none
module sop_serial_out_props
   import sop_pkg::*;
(
   input wire logic                          CLK_SYS,
   input wire logic                          RST_N,
   input wire logic [sop_pkg::SOP_PORTS-1:0] SAMPLE_VALID,
   input wire logic [sop_pkg::SOP_PORTS-1:0] SERIAL_CLOCK_OE_N,
   input wire logic [sop_pkg::SOP_PORTS-1:0] FRAME_SYNC_O,
   input wire logic [sop_pkg::SOP_PORTS-1:0] FRAME_SYNC_OE_N,
   input wire logic [sop_pkg::SOP_PORTS-1:0] SERIAL_DATA_OUT,
   input wire logic [sop_pkg::SOP_PORTS-1:0] SERIAL_DATA_OUT_OE_N,
   input wire logic [sop_pkg::SOP_PORTS-1:0] FRAME_END,
   input wire logic [sop_pkg::SOP_PORTS-1:0] FRAME_READY_FLAG
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);
   for (genvar p = 0; p < SOP_PORTS; p++)
   begin : g_port
      oe_pair_a: assert property (SERIAL_CLOCK_OE_N[p] == FRAME_SYNC_OE_N[p])
         else $error("clock and sync enables disagree");
      ready_set_a: assert property (SAMPLE_VALID[p] |=> FRAME_READY_FLAG[p])
         else $error("ready flag not set after a sample");
      idle_steady_a: assert property (SERIAL_DATA_OUT_OE_N[p] && $past(SERIAL_DATA_OUT_OE_N[p])
         |-> $stable(SERIAL_DATA_OUT[p])) else $error("idle serial data changed");
      end_in_frame_a: assert property (FRAME_END[p] |-> !SERIAL_DATA_OUT_OE_N[p])
         else $error("frame end outside a frame");
      end_short_a: assert property ($rose(FRAME_END[p]) |-> ##[1:40] !FRAME_END[p])
         else $error("frame end held too long");
      end_then_idle_a: assert property ($fell(FRAME_END[p]) |-> SERIAL_DATA_OUT_OE_N[p])
         else $error("data still driven after frame end");
      end_after_data_a: assert property ($rose(FRAME_END[p]) |-> !$past(SERIAL_DATA_OUT_OE_N[p]))
         else $error("frame end on first bit");
      sync_then_data_a: assert property ($rose(FRAME_SYNC_O[p]) && SERIAL_DATA_OUT_OE_N[p]
         && !FRAME_SYNC_OE_N[p] |-> ##[1:16] !SERIAL_DATA_OUT_OE_N[p]) else $error("no data after sync");
   end
   cover property (FRAME_END[0] && !FRAME_SYNC_OE_N[0]);
   cover property (FRAME_END[1] && FRAME_SYNC_OE_N[1]);
   cover property (FRAME_READY_FLAG[2] && !FRAME_SYNC_OE_N[2]);
endmodule // sop_serial_out_props
bind sop_serial_out sop_serial_out_props sop_serial_out_props_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
   .SAMPLE_VALID(SAMPLE_VALID), .SERIAL_CLOCK_OE_N(SERIAL_CLOCK_OE_N), .FRAME_SYNC_O(FRAME_SYNC_O),
   .FRAME_SYNC_OE_N(FRAME_SYNC_OE_N), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
   .SERIAL_DATA_OUT_OE_N(SERIAL_DATA_OUT_OE_N), .FRAME_END(FRAME_END), .FRAME_READY_FLAG(FRAME_READY_FLAG));
`default_nettype wire

/* sim/sop_dsp_model.sv */
// Behavioural DSP serial port: clocks slave ports and captures any frame.
`timescale 1ns/1ps
`default_nettype none
module sop_dsp_model
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       clr,
   input  wire logic       serve,
   input  wire logic [5:0] nbits,
   input  wire logic       sclk_line,
   input  wire logic       fs_line,
   input  wire logic       sd,
   input  wire logic       sd_oe_n,
   input  wire logic       fe,
   output logic            sclk_o,
   output logic            fs_o,
   output logic [47:0]     rx,
   output logic [6:0]      rx_n,
   output logic [6:0]      n_sync,
   output logic [6:0]      n_end
);
   logic [8:0] cnt;
   logic       run;
   logic       sclk_q;
   // The clock stands still between frames; sync covers the whole first period.
   assign sclk_o = run & cnt[1];
   assign fs_o = run & (cnt < 9'h004);
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         run <= 1'b0;
         cnt <= 9'h000;
      end
      else if (serve)
      begin
         run <= 1'b1;
         cnt <= 9'h000;
      end
      else if (run)
      begin
         cnt <= cnt + 9'h001;
         if (cnt == ({3'h0, nbits} << 2) + 9'h00B)
            run <= 1'b0;
      end
   // On a slave port the rising serial edge sees the bit launched one period earlier; on a master port, the bit launched one clock earlier.
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         sclk_q <= 1'b0;
         rx <= 48'h0;
         rx_n <= 7'h00;
         n_sync <= 7'h00;
         n_end <= 7'h00;
      end
      else
      begin
         sclk_q <= sclk_line;
         if (clr)
         begin
            rx <= 48'h0;
            rx_n <= 7'h00;
            n_sync <= 7'h00;
            n_end <= 7'h00;
         end
         else if (sclk_line && !sclk_q)
         begin
            if (!sd_oe_n)
            begin
               rx <= {rx[46:0], sd};
               rx_n <= rx_n + 7'h01;
            end
            if (fs_line)
               n_sync <= n_sync + 7'h01;
            if (fe)
               n_end <= n_end + 7'h01;
         end
      end
endmodule // sop_dsp_model
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the four-port serial I/Q output block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sop_pkg::*;
   logic clk, rst_n, wr, rd, strap, clr, serve, m_sclk, m_fs;
   logic [9:0] addr;
   logic [15:0] wdata, rdata;
   logic [3:0] div0, dec20, svld, sclk_i, sclk_o, sclk_oe_n, fs_i, fs_o, fs_oe_n, serial_data_out, sdo_oe_n, fend, rdy;
   logic [3:0][23:0] si, sq;
   logic [47:0] rx;
   logic [6:0] rx_n, n_sync, n_end;
   logic [5:0] nb;
   logic [1:0] sel;
   logic [31:0] rs;
   logic [23:0] i, q, a, b;
   int bad_count, n_checks, cyc, w, e;
   time t0;
   sop_serial_out sop_serial_out_inst (.CLK_SYS(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .BUS_MASTER_SELECT0(strap), .SERIAL_CLOCK_DIVIDER0(div0), .DECIM_IS_20(dec20),
      .SAMPLE_VALID(svld), .SAMPLE_I(si), .SAMPLE_Q(sq), .SERIAL_CLOCK_I(sclk_i), .SERIAL_CLOCK_O(sclk_o),
      .SERIAL_CLOCK_OE_N(sclk_oe_n), .FRAME_SYNC_I(fs_i), .FRAME_SYNC_O(fs_o), .FRAME_SYNC_OE_N(fs_oe_n),
      .SERIAL_DATA_OUT(serial_data_out), .SERIAL_DATA_OUT_OE_N(sdo_oe_n), .FRAME_END(fend), .FRAME_READY_FLAG(rdy));
   sop_dsp_model sop_dsp_model_inst (.clk(clk), .rst_n(rst_n), .clr(clr), .serve(serve), .nbits(nb),
      .sclk_line(sclk_i[sel]), .fs_line(fs_i[sel]), .sd(serial_data_out[sel]), .sd_oe_n(sdo_oe_n[sel]), .fe(fend[sel]),
      .sclk_o(m_sclk), .fs_o(m_fs), .rx(rx), .rx_n(rx_n), .n_sync(n_sync), .n_end(n_end));
   always_comb
      for (int p = 0; p < 4; p++)
      begin
         sclk_i[p] = sclk_oe_n[p] ? (sel == p) && m_sclk : sclk_o[p];
         fs_i[p] = fs_oe_n[p] ? (sel == p) && m_fs : fs_o[p];
      end
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [47:0] ex, input logic [47:0] got);
      n_checks++;
      if (got !== ex)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic wreg(input logic [1:0] p, input logic [7:0] o, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= {p, o};
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [1:0] p, input logic [7:0] o, input logic [15:0] ex, input string nm);
      @(posedge clk);
      rd <= 1'b1;
      addr <= {p, o};
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(nm, {32'h0, ex}, {32'h0, rdata});
   endtask
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function automatic int fexp(input logic [23:0] x, input int m);
      int v;
      v = $signed(x);
      for (int s = 0; s < 15; s++)
         if ((v >>> s) < (1 << (m - 1)) && (v >>> s) >= -(1 << (m - 1)))
            return s;
      return 15;
   endfunction
   function automatic logic [23:0] fw(input logic [23:0] x, input int s, input int m, input int wl);
      logic [23:0] v;
      v = ((($signed(x) >>> s) & ((1 << m) - 1)) << 4) | s;
      return (wl >= m + 4) ? v << (wl - m - 4) : v >> (m + 4 - wl);
   endfunction
   function automatic logic [47:0] expf(input logic [23:0] x, y, input int wl, f, input bit cm, fo, input int sc);
      int ex, ey, m;
      logic [23:0] u, t;
      m = (f == 2) ? 12 : 8;
      ex = fo ? sc : fexp(x, m);
      ey = fo ? sc : fexp(y, m);
      if (cm)
      begin
         ex = (ex > ey) ? ex : ey;
         ey = ex;
      end
      u = (f == 0) ? (x << sc) >> (24 - wl) : fw(x, ex, m, wl);
      t = (f == 0) ? (y << sc) >> (24 - wl) : fw(y, ey, m, wl);
      return ({24'h0, u} << wl) | {24'h0, t};
   endfunction
   task automatic frame(input logic [1:0] p, input int n, input logic [47:0] ex, input bit slave, input int ns);
      int k;
      @(posedge clk);
      sel <= p;
      nb <= n[5:0];
      clr <= 1'b1;
      svld[p] <= 1'b1;
      si[p] <= i;
      sq[p] <= q;
      @(posedge clk);
      clr <= 1'b0;
      svld[p] <= 1'b0;
      @(negedge clk);
      chk("ready set", 48'h1, {47'h0, rdy[p]});
      if (slave)
      begin
         @(posedge clk);
         serve <= 1'b1;
         @(posedge clk);
         serve <= 1'b0;
      end
      k = 0;
      while ((rx_n < n || sdo_oe_n[p] !== 1'b1) && k < 3000)
      begin
         @(negedge clk);
         k++;
      end
      chk("frame bits", ex, rx & ((48'h1 << n) - 48'h1));
      chk("bit count", 48'(n), {41'h0, rx_n});
      chk("ready clear", 48'h0, {47'h0, rdy[p]});
      chk("frame end count", 48'h1, {41'h0, n_end});
      if (ns > 0)
         chk("sync count", 48'(ns), {41'h0, n_sync});
      $display("frame test on port %0d done", p);
   endtask
   initial
   begin
      rs = 32'h64ED4DBC;
      {sel, nb, clr, serve, wr, rd, addr, wdata, dec20, svld, si, sq} = '0;
      {bad_count, n_checks, cyc} = '0;
      strap = 1'b1;
      div0 = 4'h1;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rchk(2'h1, SOP_OFS_FORMAT, SOP_FMT_RESET, "format reset");
      rchk(2'h1, SOP_OFS_PORTCFG, SOP_CFG_RESET, "config reset");
      rchk(2'h1, SOP_OFS_STATUS, 16'h0000, "slave status");
      rchk(2'h0, SOP_OFS_STATUS, 16'h0004, "strap master status");
      rchk(2'h1, 8'h10, 16'h0000, "unmapped read");
      chk("port roles", 48'hE, {44'h0, sclk_oe_n});
      wreg(2'h3, SOP_OFS_FORMAT, 16'h03D6);
      rchk(2'h3, SOP_OFS_FORMAT, 16'h03D6, "format readback");
      for (int md = 0; md < 3; md++)
         for (int wl = 0; wl < 3; wl++)
         begin
            w = (wl == 2) ? 24 : 12 + 4 * wl;
            wreg(2'h0, SOP_OFS_FORMAT, 16'(md * 4 + wl));
            i = 24'(rnd());
            q = 24'(rnd());
            frame(2'h0, 2 * w, expf(i, q, w, 0, 0, 0, 0), 0, md == 0 ? 1 : md == 1 ? 2 * w : 2);
         end
      wreg(2'h2, SOP_OFS_PORTCFG, 16'h0012);
      wreg(2'h2, SOP_OFS_FORMAT, 16'h0302);
      rchk(2'h2, SOP_OFS_STATUS, 16'h0004, "register master status");
      wait (sclk_o[2] === 1'b0);
      wait (sclk_o[2] === 1'b1);
      t0 = $time;
      wait (sclk_o[2] === 1'b0);
      wait (sclk_o[2] === 1'b1);
      chk("serial clock period", 48'd75, 48'($time - t0));
      i = 24'($signed(rnd()) >>> 13);
      q = 24'($signed(rnd()) >>> 13);
      frame(2'h2, 48, expf(i, q, 24, 0, 0, 0, 3), 0, 1);
      wreg(2'h1, SOP_OFS_FORMAT, 16'h0011);
      i = 24'(rnd());
      q = 24'($signed(rnd()) >>> 14);
      frame(2'h1, 32, expf(i, q, 16, 1, 0, 0, 0), 1, 0);
      wreg(2'h1, SOP_OFS_FORMAT, 16'h0462);
      i = 24'($signed(rnd()) >>> 16);
      q = 24'($signed(rnd()) >>> 16);
      frame(2'h1, 48, expf(i, q, 24, 2, 0, 1, 4), 1, 0);
      wreg(2'h1, SOP_OFS_FORMAT, 16'h0092);
      i = 24'(rnd());
      q = 24'($signed(rnd()) >>> 12);
      frame(2'h1, 48, expf(i, q, 24, 1, 1, 0, 0), 1, 0);
      @(posedge clk);
      dec20 <= 4'h2;
      e = (fexp(i, 8) > fexp(q, 8)) ? fexp(i, 8) : fexp(q, 8);
      a = fw(i, e, 8, 12);
      b = fw(q, e, 8, 12);
      frame(2'h1, 20, {28'h0, a[11:0], b[11:4]}, 1, 0);
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
